/* hdl/config_word_one_map.svh */
// Constants for the first configuration word: field positions, erased value, array tops.
// Assumes inclusion by bare name from the design modules.
`ifndef CONFIG_WORD_ONE_MAP_SVH
`define CONFIG_WORD_ONE_MAP_SVH

`define CW1_WIDTH 14
`define CW1_OFFSET 1'h0
`define CW1_ERASED 14'h3fff
// Bits that always read as one: 11, 10, 7 and 2.
`define CW1_UNIMPL_MASK 14'h0c84
`define CW1_BIT_PLL 12
`define CW1_BIT_BOR_HI 9
`define CW1_BIT_BOR_LO 8
`define CW1_BIT_PROTECT 6
`define CW1_BIT_RESET_SEL 5
`define CW1_BIT_POWERUP_DELAY_N 4
`define CW1_BIT_WATCHDOG 3
`define CW1_BIT_OSC_HI 1
`define CW1_BIT_OSC_LO 0
`define CW1_TOP_SMALL 12'h7ff
`define CW1_TOP_LARGE 12'hfff
`define CW1_FREQ_LOW_KHZ 500
`define CW1_FREQ_HIGH_KHZ 16000
`define CW1_FREQ_MULT 32

`endif

/* hdl/config_word_one_pkg.sv */
// Types shared by the configuration decode files.
// Assumes nothing beyond the map header.
package config_word_one_pkg;
	typedef enum logic [1:0] {
		LOAD_IDLE = 2'b00,
		LOAD_BUSY = 2'b01,
		LOAD_DONE = 2'b10
	} load_state_t;
	typedef logic [13:0] cfg_word_t;
endpackage

/* hdl/prot_range_check.sv */
// Code-protection address check for program memory.
// Assumes the address comes from the same clock domain as the caller.
`timescale 1ns/1ps
`include "config_word_one_map.svh"
module prot_range_check (
	input wire logic large_array,
	input wire logic protect_on,
	input wire logic [11:0] addr,
	output logic addr_protected
);
	logic [11:0] top;
	// Protection runs from address zero to the top of the fitted array.
	always_comb begin
		top = large_array ? `CW1_TOP_LARGE : `CW1_TOP_SMALL;
		addr_protected = protect_on && (addr <= top); // R2
	end
endmodule

/* hdl/config_word_one_decode.sv */
// Holds and decodes the first configuration word into device controls.
// Assumes the word is loaded once after reset from configuration memory.
//
// Notes on behaviour
// R1 - Unimplemented bits 11, 10, 7 and 2 always read as one.
// R2 - Protect bit clear protects memory from zero to array top.
// R3 - Reset select set: pin is external reset, weak pull-up on.
// R4 - Reset select clear: pin is digital input only, pull-up off.
// R5 - Power-up delay timer runs when its enable bit is zero.
// R6 - Watchdog runs when its enable bit is one.
// R7 - Frequency bit picks 500 kHz or 16 MHz oscillator output.
`timescale 1ns/1ps
`include "config_word_one_map.svh"
module config_word_one_decode (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic large_array,
	input wire logic cfg_load,
	input wire logic [13:0] cfg_data,
	input wire logic reg_addr,
	input wire logic [13:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [13:0] reg_rdata,
	input wire logic pin_level,
	input wire logic [11:0] fetch_addr,
	output logic fetch_protected,
	output logic flash_read_protect,
	output logic external_reset_input_n,
	output logic reset_pin_pullup,
	output logic digital_input_level,
	output logic powerup_delay_timer_en,
	output logic watchdog_counter_en,
	output logic osc_full_rate,
	output logic [1:0] osc_select,
	output logic [1:0] bor_mode,
	output logic cfg_valid
);
	config_word_one_pkg::cfg_word_t word_reg, word_next;
	config_word_one_pkg::load_state_t state_reg, state_next;
	logic [13:0] rdata_reg, rdata_next;
	logic [13:0] word_view;

	// Stored word with unimplemented positions forced high.
	assign word_view = word_reg | `CW1_UNIMPL_MASK; // R1

	// Next-state logic: load from memory, or a programmer write.
	always_comb begin
		word_next = word_reg;
		state_next = state_reg;
		rdata_next = rdata_reg;
		case (state_reg)
			config_word_one_pkg::LOAD_IDLE: begin
				state_next = config_word_one_pkg::LOAD_BUSY;
			end
			config_word_one_pkg::LOAD_BUSY: begin
				if (cfg_load) begin
					word_next = cfg_data;
					state_next = config_word_one_pkg::LOAD_DONE;
				end
			end
			config_word_one_pkg::LOAD_DONE: begin
				if (reg_wr && reg_addr == `CW1_OFFSET) begin
					word_next = reg_wdata;
				end
			end
			default: begin
				state_next = config_word_one_pkg::LOAD_IDLE;
			end
		endcase
		if (reg_rd) begin
			rdata_next = (reg_addr == `CW1_OFFSET) ? word_view : 14'h0000; // R1
		end else begin
			rdata_next = 14'h0000;
		end
	end

	// Registers; the erased word stands until a load arrives.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			word_reg <= `CW1_ERASED;
			state_reg <= config_word_one_pkg::LOAD_IDLE;
			rdata_reg <= 14'h0000;
		end else if (clk_en) begin
			word_reg <= word_next;
			state_reg <= state_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign cfg_valid = (state_reg == config_word_one_pkg::LOAD_DONE);

	// Field decode into device controls.
	always_comb begin
		flash_read_protect = !word_view[`CW1_BIT_PROTECT]; // R2
		external_reset_input_n = word_view[`CW1_BIT_RESET_SEL] ? pin_level : 1'b1; // R3 R4
		reset_pin_pullup = word_view[`CW1_BIT_RESET_SEL]; // R3 R4
		digital_input_level = word_view[`CW1_BIT_RESET_SEL] ? 1'b0 : pin_level; // R4
		powerup_delay_timer_en = !word_view[`CW1_BIT_POWERUP_DELAY_N]; // R5
		watchdog_counter_en = word_view[`CW1_BIT_WATCHDOG]; // R6
		osc_full_rate = word_view[`CW1_BIT_PLL]; // R7
		osc_select = word_view[`CW1_BIT_OSC_HI:`CW1_BIT_OSC_LO];
		bor_mode = word_view[`CW1_BIT_BOR_HI:`CW1_BIT_BOR_LO];
	end

	// Address check against the protected range.
	prot_range_check prot_range_check_inst (
		.large_array(large_array),
		.protect_on(flash_read_protect),
		.addr(fetch_addr),
		.addr_protected(fetch_protected)
	);

	// A read strobe at the mapped address on an enabled edge.
	sequence s_cfg_read;
		reg_rd && !reg_addr && clk_en;
	endsequence

	// A read strobe at the unmapped address on an enabled edge.
	sequence s_unmapped_read;
		reg_rd && reg_addr && clk_en;
	endsequence

	// A load strobe that the wait state takes on an enabled edge.
	sequence s_load_accept;
		cfg_load && clk_en && state_reg == config_word_one_pkg::LOAD_BUSY;
	endsequence

	// A loaded word with no programmer write on this edge.
	sequence s_word_settled;
		cfg_valid && !reg_wr;
	endsequence

	// Every read of the word shows the unimplemented positions as ones.
	property p_unimpl_ones;
		@(posedge ref_clk) disable iff (sys_rst)
		s_cfg_read |=> (reg_rdata & `CW1_UNIMPL_MASK) == `CW1_UNIMPL_MASK;
	endproperty
	a_unimpl_ones: assert property (p_unimpl_ones) else $error("unimplemented bit read zero"); // R1

	// A read of the unmapped address answers zero.
	property p_unmapped_zero;
		@(posedge ref_clk) disable iff (sys_rst)
		s_unmapped_read |=> reg_rdata == 14'h0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // R1

	// Read data stand only in the cycle after a strobe.
	property p_rdata_idle;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && !reg_rd |=> reg_rdata == 14'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe"); // R1

	// Protection covers address zero whenever the protect bit is clear.
	property p_protect;
		@(posedge ref_clk) disable iff (sys_rst)
		!word_reg[`CW1_BIT_PROTECT] && fetch_addr == 12'h000 |-> fetch_protected;
	endproperty
	a_protect: assert property (p_protect) else $error("address zero not protected"); // R2

	// With the protect bit set no address is protected.
	property p_protect_off;
		@(posedge ref_clk) disable iff (sys_rst)
		word_reg[`CW1_BIT_PROTECT] |-> !fetch_protected;
	endproperty
	a_protect_off: assert property (p_protect_off) else $error("protection on while off"); // R2

	// On the small array the range ends at its top address.
	property p_protect_top;
		@(posedge ref_clk) disable iff (sys_rst)
		flash_read_protect && !large_array && fetch_addr > `CW1_TOP_SMALL |-> !fetch_protected;
	endproperty
	a_protect_top: assert property (p_protect_top) else $error("range past small top"); // R2

	// On the large array every fetch address is inside the range.
	property p_protect_large;
		@(posedge ref_clk) disable iff (sys_rst)
		flash_read_protect && large_array |-> fetch_protected;
	endproperty
	a_protect_large: assert property (p_protect_large) else $error("large array gap"); // R2

	// An accepted load takes the whole word and marks it valid.
	property p_load_word;
		@(posedge ref_clk) disable iff (sys_rst)
		s_load_accept |=> cfg_valid && word_reg == $past(cfg_data);
	endproperty
	a_load_word: assert property (p_load_word) else $error("load not taken"); // R2

	// Before the load nothing but the load may change the word.
	property p_early_write;
		@(posedge ref_clk) disable iff (sys_rst)
		!cfg_valid && !cfg_load |=> $stable(word_reg);
	endproperty
	a_early_write: assert property (p_early_write) else $error("word changed before load"); // R2

	// Once loaded, a later load strobe leaves the word alone.
	property p_load_once;
		@(posedge ref_clk) disable iff (sys_rst)
		s_word_settled |=> $stable(word_reg);
	endproperty
	a_load_once: assert property (p_load_once) else $error("word changed without write"); // R2

	// A low clock enable freezes the word and the load state.
	property p_freeze;
		@(posedge ref_clk) disable iff (sys_rst)
		!clk_en |=> $stable(word_reg) && $stable(state_reg);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // R2

	// Reset select set routes the pin to reset and turns the pull-up on.
	property p_reset_pin;
		@(posedge ref_clk) disable iff (sys_rst)
		word_reg[`CW1_BIT_RESET_SEL] |-> reset_pin_pullup && external_reset_input_n == pin_level;
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin not routed"); // R3

	// Reset select clear leaves a plain input with the pull-up off.
	property p_digital_pin;
		@(posedge ref_clk) disable iff (sys_rst)
		!word_reg[`CW1_BIT_RESET_SEL] |-> !reset_pin_pullup && external_reset_input_n &&
			digital_input_level == pin_level;
	endproperty
	a_digital_pin: assert property (p_digital_pin) else $error("digital pin mode wrong"); // R4

	// The power-up delay enable is active low.
	property p_powerup_delay;
		@(posedge ref_clk) disable iff (sys_rst)
		powerup_delay_timer_en == !word_reg[`CW1_BIT_POWERUP_DELAY_N];
	endproperty
	a_powerup_delay: assert property (p_powerup_delay) else $error("power-up delay wrong"); // R5

	// The watchdog enable is active high.
	property p_watchdog;
		@(posedge ref_clk) disable iff (sys_rst)
		watchdog_counter_en == word_reg[`CW1_BIT_WATCHDOG];
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("watchdog polarity wrong"); // R6

	// The frequency bit of a loaded word reaches the oscillator rate output.
	property p_freq;
		@(posedge ref_clk) disable iff (sys_rst)
		s_load_accept |=> osc_full_rate == $past(cfg_data[`CW1_BIT_PLL]);
	endproperty
	a_freq: assert property (p_freq) else $error("frequency select not loaded"); // R7

	// Oscillator and brown-out fields pass through as stored.
	property p_fields_pass;
		@(posedge ref_clk) disable iff (sys_rst)
		osc_select == word_reg[`CW1_BIT_OSC_HI:`CW1_BIT_OSC_LO] &&
			bor_mode == word_reg[`CW1_BIT_BOR_HI:`CW1_BIT_BOR_LO];
	endproperty
	a_fields_pass: assert property (p_fields_pass) else $error("field not passed through"); // R7
endmodule

/* tb/config_word_one_decode_tb.sv */
// Self-checking bench for the first configuration word decode.
// Assumes the design files under hdl/ are compiled first.
`timescale 1ns/1ps
module config_word_one_decode_tb;
	logic ref_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, large_array = 1'h0, cfg_load = 1'h0;
	logic reg_addr = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, pin_level = 1'h0;
	logic [13:0] cfg_data = 14'h0000, reg_wdata = 14'h0000, reg_rdata;
	logic [11:0] fetch_addr = 12'h000;
	logic fetch_protected, flash_read_protect, external_reset_input_n, reset_pin_pullup;
	logic digital_input_level, powerup_delay_timer_en, watchdog_counter_en, osc_full_rate;
	logic [1:0] osc_select, bor_mode;
	logic cfg_valid;
	int mismatches = 0, checked = 0, cycles = 0;
	// Compares a seen value with the expected one and counts the outcome.
	`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; \
		$display("[ERR] %s expected %h seen %h", nm, ex, got); end end
	config_word_one_decode config_word_one_decode_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .large_array(large_array), .cfg_load(cfg_load), .cfg_data(cfg_data),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pin_level(pin_level), .fetch_addr(fetch_addr),
		.fetch_protected(fetch_protected), .flash_read_protect(flash_read_protect),
		.external_reset_input_n(external_reset_input_n), .reset_pin_pullup(reset_pin_pullup),
		.digital_input_level(digital_input_level), .powerup_delay_timer_en(powerup_delay_timer_en),
		.watchdog_counter_en(watchdog_counter_en), .osc_full_rate(osc_full_rate),
		.osc_select(osc_select), .bor_mode(bor_mode), .cfg_valid(cfg_valid));
	// Makes the 50 MHz clock.
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	// Cuts a hang short after far more cycles than the tests need.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			report_and_stop();
		end
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// One-cycle write strobe beside address and data.
	task automatic wr(input logic a, input logic [13:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
		#1;
	endtask
	// One-cycle read strobe; the data is compared in the following cycle.
	task automatic rd(input logic a, input logic [13:0] ex);
		@(posedge ref_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1;
		`CHK("rdata", ex, reg_rdata)
	endtask
	// Sets the fetch address and array size, then checks the protection answer.
	task automatic fetch(input logic big, input logic [11:0] a, input logic ex);
		@(posedge ref_clk);
		large_array <= big;
		fetch_addr <= a;
		#1;
		`CHK("fetch_protected", ex, fetch_protected)
	endtask
	// Tries a write before the load, loads an all-zero word, walks every field, then resets.
	initial begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'h0;
		wr(1'h0, 14'h0000);
		`CHK("valid", 1'h0, cfg_valid)
		`CHK("protect", 1'h0, flash_read_protect)
		`CHK("pullup", 1'h1, reset_pin_pullup)
		`CHK("powerup_delay", 1'h0, powerup_delay_timer_en)
		`CHK("watchdog", 1'h1, watchdog_counter_en)
		`CHK("osc", 1'h1, osc_full_rate)
		`CHK("osc_select", 2'h3, osc_select)
		`CHK("bor_mode", 2'h3, bor_mode)
		@(posedge ref_clk);
		cfg_load <= 1'h1;
		@(posedge ref_clk);
		cfg_load <= 1'h0;
		#1;
		`CHK("valid", 1'h1, cfg_valid)
		`CHK("protect", 1'h1, flash_read_protect)
		`CHK("pullup", 1'h0, reset_pin_pullup)
		`CHK("powerup_delay", 1'h1, powerup_delay_timer_en)
		`CHK("watchdog", 1'h0, watchdog_counter_en)
		`CHK("osc", 1'h0, osc_full_rate)
		`CHK("osc_select", 2'h0, osc_select)
		`CHK("bor_mode", 2'h0, bor_mode)
		@(posedge ref_clk);
		cfg_data <= 14'h3fff;
		cfg_load <= 1'h1;
		@(posedge ref_clk);
		cfg_load <= 1'h0;
		#1;
		`CHK("protect", 1'h1, flash_read_protect)
		rd(1'h0, 14'h0c84);
		fetch(1'h0, 12'h7ff, 1'h1);
		fetch(1'h0, 12'h800, 1'h0);
		fetch(1'h0, 12'h000, 1'h1);
		fetch(1'h1, 12'hfff, 1'h1);
		@(posedge ref_clk);
		pin_level <= 1'h1;
		#1;
		`CHK("rst_n", 1'h1, external_reset_input_n)
		`CHK("din", 1'h1, digital_input_level)
		wr(1'h0, 14'h3fff);
		`CHK("pullup", 1'h1, reset_pin_pullup)
		`CHK("powerup_delay", 1'h0, powerup_delay_timer_en)
		`CHK("watchdog", 1'h1, watchdog_counter_en)
		`CHK("osc", 1'h1, osc_full_rate)
		`CHK("osc_select", 2'h3, osc_select)
		`CHK("din", 1'h0, digital_input_level)
		@(posedge ref_clk);
		pin_level <= 1'h0;
		#1;
		`CHK("rst_n", 1'h0, external_reset_input_n)
		fetch(1'h1, 12'h000, 1'h0);
		@(posedge ref_clk);
		clk_en <= 1'h0;
		wr(1'h0, 14'h0000);
		`CHK("frozen", 1'h0, flash_read_protect)
		@(posedge ref_clk);
		clk_en <= 1'h1;
		wr(1'h1, 14'h0000);
		rd(1'h1, 14'h0000);
		rd(1'h0, 14'h3fff);
		wr(1'h0, 14'h0040);
		`CHK("protect", 1'h0, flash_read_protect)
		`CHK("pullup", 1'h0, reset_pin_pullup)
		`CHK("osc", 1'h0, osc_full_rate)
		rd(1'h0, 14'h0cc4);
		@(posedge ref_clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'h0;
		#1;
		`CHK("valid", 1'h0, cfg_valid)
		`CHK("pullup", 1'h1, reset_pin_pullup)
		`CHK("osc", 1'h1, osc_full_rate)
		`CHK("rdata", 14'h0000, reg_rdata)
		report_and_stop();
	end
endmodule
